// file: verilog/cmp_pkg.sv
// Overview of operation
// - output-state bit reads comparator result, positive above negative is 1; read only.
// - rising comparator transition sets rise flag; it holds until software writes 0.
// - falling transition sets fall flag; holds until cleared, 0 if none since clear.
// - positive hysteresis bits 3:2: 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
// - negative hysteresis bits 1:0: 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
package cmp_pkg;
    // register index; the byte address is four times it
    localparam logic [9:0]  IDX_CONTROL       = 10'h09a;
    localparam logic [9:0]  IDX_INPUT_SELECT  = 10'h09c;
    localparam logic [11:0] ADDR_CONTROL      = {IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_INPUT_SELECT = {IDX_INPUT_SELECT, 2'b00};
    localparam logic [7:0]  CONTROL_RESET     = 8'h00;
    localparam logic [7:0]  INPUT_SELECT_RESET = 8'h77;
    localparam int          BIT_ENABLE        = 7;
    localparam int          BIT_OUTPUT_STATE  = 6;
    localparam int          BIT_RISE          = 5;
    localparam int          BIT_FALL          = 4;
    localparam int          HYP_MSB           = 3;
    localparam int          HYP_LSB           = 2;
    localparam int          HYN_MSB           = 1;
    localparam int          HYN_LSB           = 0;
    localparam int          NEG_MSB           = 7;
    localparam int          NEG_LSB           = 4;
    localparam int          POS_MSB           = 3;
    localparam int          POS_LSB           = 0;
    localparam int          NUM_SOURCES       = 12;
    localparam logic [3:0]  LAST_SOURCE       = 4'hb;
    localparam int          NUM_PINS          = 24;
    localparam logic [23:0] PIN_CONNECT_RESET = 24'h00_c000;
endpackage

// file: verilog/cmp_input_mux.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_input_mux (
    // selection codes
    input  wire logic [3:0]                 pos_input_select,
    input  wire logic [3:0]                 neg_input_select,
    // pin connects, at most one positive and one negative pin set
    output logic [cmp_pkg::NUM_PINS-1:0]    pin_connect
);
    import cmp_pkg::*;

    genvar i;
    generate
        for (i = 0; i < NUM_SOURCES; i = i + 1) begin : g_src
            // even pins positive, odd pins negative
            assign pin_connect[2*i]   = (pos_input_select == 4'(i));
            assign pin_connect[2*i+1] = (neg_input_select == 4'(i));
        end
    endgenerate
endmodule
`default_nettype wire

// file: verilog/comparator_control_regs.sv
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module comparator_control_regs (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    // analog comparator core
    input  wire logic                       cmp_raw_out,
    output logic                            cmp_power_on,
    output logic [1:0]                      cmp_pos_hysteresis,
    output logic [1:0]                      cmp_neg_hysteresis,
    // port pin multiplexer
    output logic [cmp_pkg::NUM_PINS-1:0]    pin_connect
);
    import cmp_pkg::*;

    // register fields
    logic                       cmp_enable;
    logic                       cmp_rise_flag;
    logic                       cmp_fall_flag;
    logic [3:0]                 neg_input_select;
    logic [3:0]                 pos_input_select;
    logic [7:0]                 comparator_input_select;

    // comparator output path
    logic                       sync_a;
    logic                       sync_b;
    logic                       cmp_prev;
    logic                       cmp_output_state;
    logic                       rise_event;
    logic                       fall_event;

    // bus decode and read path
    logic                       access;
    logic                       setup_read;
    logic                       hit_control;
    logic                       hit_select;
    logic                       wr_control;
    logic                       wr_select;
    logic [7:0]                 wr_byte;
    logic [7:0]                 control_read;
    logic [7:0]                 next_read;
    logic [NUM_PINS-1:0]        next_pin_connect;

    // one register per aligned word
    always_comb begin
        hit_control = 1'b0;
        hit_select  = 1'b0;
        case (paddr)
            ADDR_CONTROL: begin
                hit_control = 1'b1;
            end
            ADDR_INPUT_SELECT: begin
                hit_select = 1'b1;
            end
            default: begin
                hit_control = 1'b0;
            end
        endcase
    end

    // zero wait states; unmapped words answer with an error
    assign access      = psel && penable;
    assign setup_read  = psel && !penable && !pwrite;
    assign wr_control  = access && pwrite && hit_control;
    assign wr_select   = access && pwrite && hit_select;
    assign wr_byte     = pwdata[7:0];
    assign pready      = 1'b1;
    assign pslverr     = access && !hit_control && !hit_select;

    // two-flop synchroniser on the analog output
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= cmp_raw_out;
            sync_b <= sync_a;
        end
    end

    // previous-cycle copy, keeps tracking while disabled
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_prev <= 1'b0;
        end else begin
            cmp_prev <= sync_b;
        end
    end

    // reads 0 while the core is powered down
    assign cmp_output_state = cmp_enable && sync_b;

    // edge detect against the previous sample, only while enabled
    always_comb begin
        rise_event = 1'b0;
        fall_event = 1'b0;
        if (cmp_enable) begin
            rise_event = sync_b && !cmp_prev;
            fall_event = !sync_b && cmp_prev;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_enable <= CONTROL_RESET[BIT_ENABLE];
        end else if (wr_control) begin
            cmp_enable <= wr_byte[BIT_ENABLE];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_pos_hysteresis <= CONTROL_RESET[HYP_MSB:HYP_LSB];
        end else if (wr_control) begin
            cmp_pos_hysteresis <= wr_byte[HYP_MSB:HYP_LSB];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_neg_hysteresis <= CONTROL_RESET[HYN_MSB:HYN_LSB];
        end else if (wr_control) begin
            cmp_neg_hysteresis <= wr_byte[HYN_MSB:HYN_LSB];
        end
    end

    // set wins over a software clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_rise_flag <= CONTROL_RESET[BIT_RISE];
        end else if (rise_event) begin
            cmp_rise_flag <= 1'b1;
        end else if (wr_control) begin
            cmp_rise_flag <= wr_byte[BIT_RISE];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmp_fall_flag <= CONTROL_RESET[BIT_FALL];
        end else if (fall_event) begin
            cmp_fall_flag <= 1'b1;
        end else if (wr_control) begin
            cmp_fall_flag <= wr_byte[BIT_FALL];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            neg_input_select <= INPUT_SELECT_RESET[NEG_MSB:NEG_LSB];
        end else if (wr_select) begin
            neg_input_select <= wr_byte[NEG_MSB:NEG_LSB];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pos_input_select <= INPUT_SELECT_RESET[POS_MSB:POS_LSB];
        end else if (wr_select) begin
            pos_input_select <= wr_byte[POS_MSB:POS_LSB];
        end
    end

    always_comb begin
        comparator_input_select                  = 8'h00;
        comparator_input_select[NEG_MSB:NEG_LSB] = neg_input_select;
        comparator_input_select[POS_MSB:POS_LSB] = pos_input_select;
    end

    // decode the incoming code so the pins switch with the register
    cmp_input_mux u_mux (
        .pos_input_select (wr_byte[POS_MSB:POS_LSB]),
        .neg_input_select (wr_byte[NEG_MSB:NEG_LSB]),
        .pin_connect      (next_pin_connect)
    );

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_connect <= PIN_CONNECT_RESET;
        end else if (wr_select) begin
            pin_connect <= next_pin_connect;
        end
    end

    assign cmp_power_on = cmp_enable;

    // output state has no storage, so writes to it are dropped
    always_comb begin
        control_read                   = 8'h00;
        control_read[BIT_ENABLE]       = cmp_enable;
        control_read[BIT_OUTPUT_STATE] = cmp_output_state;
        control_read[BIT_RISE]         = cmp_rise_flag;
        control_read[BIT_FALL]         = cmp_fall_flag;
        control_read[HYP_MSB:HYP_LSB]  = cmp_pos_hysteresis;
        control_read[HYN_MSB:HYN_LSB]  = cmp_neg_hysteresis;
    end

    // unmapped reads return zero
    always_comb begin
        next_read = 8'h00;
        if (hit_control) begin
            next_read = control_read;
        end else if (hit_select) begin
            next_read = comparator_input_select;
        end
    end

    // read data registered during setup, valid in access phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup_read) begin
            prdata <= {24'h00_0000, next_read};
        end
    end
endmodule
`default_nettype wire

// file: dv/cmp_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model (
    input  wire logic       clk,
    input  wire logic       power_on,
    input  wire logic [7:0] v_pos,
    input  wire logic [7:0] v_neg,
    output logic            raw_out
);
    logic idle = 1'b0;
    // a powered-down core gives no steady level
    always @(posedge clk) idle <= ~idle;
    assign raw_out = power_on ? (v_pos > v_neg) : idle;
endmodule
`default_nettype wire

// file: dv/comparator_control_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module cmp_regs_sva (
    input wire logic                    clk, reset, psel, penable, pwrite, pready, pslverr,
    input wire logic                    cmp_raw_out, cmp_power_on,
    input wire logic [11:0]             paddr,
    input wire logic [31:0]             pwdata, prdata,
    input wire logic [1:0]              cmp_pos_hysteresis, cmp_neg_hysteresis,
    input wire logic [cmp_pkg::NUM_PINS-1:0] pin_connect
);
    import cmp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic wr, rd_ctl, hit;
    assign wr = psel && penable && pwrite;
    assign rd_ctl = psel && !penable && !pwrite && paddr == ADDR_CONTROL;
    assign hit = paddr == ADDR_CONTROL || paddr == ADDR_INPUT_SELECT;
    function automatic logic [NUM_PINS-1:0] pins(input logic [7:0] s);
        pins = '0;
        if (s[3:0] < 4'hc) pins[2 * s[3:0]] = 1'b1;
        if (s[7:4] < 4'hc) pins[2 * s[7:4] + 1] = 1'b1;
    endfunction
    sequence settled;
        (cmp_power_on && $stable(cmp_raw_out)) [*3];
    endsequence
    a_ready_access: assert property (psel && penable |-> pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable |-> pslverr == !hit) else $error("bad pslverr");
    a_enable_write: assert property (wr && paddr == ADDR_CONTROL |=> cmp_power_on == $past(pwdata[7]))
        else $error("enable not applied");
    a_hyst_write: assert property (wr && paddr == ADDR_CONTROL |=>
        {cmp_pos_hysteresis, cmp_neg_hysteresis} == $past(pwdata[3:0])) else $error("hysteresis wrong");
    a_mux_decode: assert property (wr && paddr == ADDR_INPUT_SELECT |=>
        pin_connect == pins($past(pwdata[7:0]))) else $error("pin connect wrong");
    a_state_follows: assert property (settled ##0 rd_ctl |=> prdata[6] == $past(cmp_raw_out))
        else $error("output state wrong");
    a_state_off: assert property (rd_ctl && !cmp_power_on |=> prdata[7:6] == 2'b00)
        else $error("state set while off");
    a_read_upper: assert property (rd_ctl |=> prdata[31:8] == 24'h0) else $error("upper bits set");
endmodule
bind comparator_control_regs cmp_regs_sva chk (.clk, .reset, .psel, .penable, .pwrite, .pready,
    .pslverr, .cmp_raw_out, .cmp_power_on, .paddr, .pwdata, .prdata, .cmp_pos_hysteresis,
    .cmp_neg_hysteresis, .pin_connect);
`default_nettype wire

// file: dv/comparator_control_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; $display("CHECK FAILED %0t mismatch", $time); end end
module comparator_control_regs_tb;
    import cmp_pkg::*;
    logic                clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]         paddr = '0;
    logic [31:0]         pwdata = '0, prdata, rd;
    logic                pready, pslverr, err, raw, pwr;
    logic [1:0]          hyp, hyn;
    logic [NUM_PINS-1:0] pins;
    logic [7:0]          v_pos = 8'h00, v_neg = 8'h00;
    int                  n_mismatch = 0, check_count = 0, cyc = 0;
    comparator_control_regs uut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmp_raw_out(raw), .cmp_power_on(pwr), .cmp_pos_hysteresis(hyp),
        .cmp_neg_hysteresis(hyn), .pin_connect(pins));
    cmp_analog_model core (.clk, .power_on(pwr), .v_pos, .v_neg, .raw_out(raw));
    initial forever #5 clk = ~clk;
    task automatic stop_test();
        if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            stop_test();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, e)
    endtask
    function automatic logic [NUM_PINS-1:0] exp_pins(input int n, input int p);
        exp_pins = '0;
        if (n < NUM_SOURCES) exp_pins[2 * n + 1] = 1'b1;
        if (p < NUM_SOURCES) exp_pins[2 * p] = 1'b1;
    endfunction
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        `CHK(pins, exp_pins(7, 7))
        rchk(ADDR_CONTROL, {24'h0, CONTROL_RESET});
        rchk(ADDR_INPUT_SELECT, {24'h0, INPUT_SELECT_RESET});
        apb(1'b1, 12'h278, 8'hff);
        `CHK(err, 1'b1)
        rchk(12'h26c, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CONTROL, 8'hc0 | 8'(i << 2) | 8'(3 - i));
            `CHK({hyp, hyn, pwr}, {2'(i), 2'(3 - i), 1'b1})
        end
        for (int n = 0; n < 16; n++) begin
            apb(1'b1, ADDR_INPUT_SELECT, {4'(n), 4'(15 - n)});
            `CHK(pins, exp_pins(n, 15 - n))
            rchk(ADDR_INPUT_SELECT, {24'h0, 4'(n), 4'(15 - n)});
        end
        v_pos <= 8'd10;
        v_neg <= 8'd5;
        repeat (4) @(posedge clk);
        apb(1'b1, ADDR_CONTROL, 8'h80);
        rchk(ADDR_CONTROL, 32'hc0);
        v_pos <= 8'd0;
        repeat (4) @(posedge clk);
        rchk(ADDR_CONTROL, 32'h90);
        repeat (8) @(posedge clk);
        rchk(ADDR_CONTROL, 32'h90);
        v_pos <= 8'd10;
        repeat (4) @(posedge clk);
        rchk(ADDR_CONTROL, 32'hf0);
        apb(1'b1, ADDR_CONTROL, 8'ha0);
        rchk(ADDR_CONTROL, 32'he0);
        apb(1'b1, ADDR_CONTROL, 8'h00);
        repeat (10) @(posedge clk);
        rchk(ADDR_CONTROL, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
